// file: hw/plrb_pkg.sv
// constants, types and register map of the panel luminance register bank
package plrb_pkg;
	// target address and register addressing
	localparam logic [6:0] DEV_ADDR7 = 7'h78; // 8-bit form 0xf0 with r/w in bit 0
	localparam int ADDR_W = 11;
	localparam logic [10:0] OFF_VALID = 11'h000;
	localparam logic [10:0] OFF_FEAT = 11'h001;
	localparam logic [10:0] OFF_START_LO = 11'h002;
	localparam logic [10:0] OFF_P0 = 11'h003;
	localparam logic [10:0] OFF_P7 = 11'h00a;
	localparam logic [10:0] OFF_REFRESH = 11'h00b;
	localparam logic [10:0] OFF_GAIN = 11'h016;
	localparam logic [10:0] OFF_SYNC = 11'h040;
	localparam logic [10:0] OFF_HYST = 11'h041;
	localparam logic [10:0] OFF_MID_HI = 11'h048;
	localparam logic [10:0] OFF_MID_LO = 11'h049;
	localparam logic [10:0] OFF_GID_HI = 11'h04a;
	localparam logic [10:0] OFF_GID_LO = 11'h04b;
	localparam logic [10:0] OFF_PEAK_HI = 11'h04c;
	localparam logic [10:0] OFF_PEAK_LO = 11'h04d;
	localparam logic [10:0] OFF_TXC_HI = 11'h04e;
	localparam logic [10:0] OFF_TXC_LO = 11'h04f;
	localparam logic [10:0] OFF_INIT_HI = 11'h050;
	localparam logic [10:0] OFF_INIT_LO = 11'h051;
	localparam logic [10:0] OFF_BAL = 11'h05d;
	localparam logic [10:0] OFF_TEMP_HI = 11'h05e;
	localparam logic [10:0] OFF_TEMP_LO = 11'h05f;
	// field positions
	localparam int FEAT_LIMIT_BIT = 6;
	localparam int FEAT_PDOWN_BIT = 4;
	localparam int REFRESH_DIS_BIT = 4;
	localparam int BAL_EN_BIT = 7;
	// writable bits of each register, others read zero
	localparam logic [7:0] FEAT_MASK = 8'h53;
	localparam logic [7:0] REFRESH_MASK = 8'h10;
	localparam logic [7:0] BAL_MASK = 8'h80;
	localparam logic [7:0] SYNC_MASK = 8'h0f;
	localparam logic [7:0] HI2_MASK = 8'h03;
	// reset values
	localparam logic [7:0] FEAT_RST = 8'h40;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [7:0] GAIN_RST = 8'hff;
	// peak synchronisation field codes
	localparam logic [1:0] SYNC_ON = 2'h3;
	localparam logic [1:0] WIN_2 = 2'h1;
	localparam logic [1:0] WIN_4 = 2'h2;
	localparam logic [1:0] WIN_8 = 2'h3;
	// brightness curve geometry
	localparam int NUM_PTS = 8;
	localparam logic [10:0] PT_SPACING = 11'h080;
	localparam logic [10:0] APL_MAX = 11'h3ff;
	// curve configuration travelling as one bundle
	typedef struct packed {
		logic [9:0] start;
		logic [7:0][7:0] level;
		logic [7:0] gain;
	} plrb_curve_cfg_type;
	// target port sequencer states
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_DEV = 6'h02,
		ST_ADRH = 6'h04,
		ST_ADRL = 6'h08,
		ST_WR = 6'h10,
		ST_RD = 6'h20
	} plrb_state_type;
endpackage

// file: hw/plrb_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module plrb_sync #(
	parameter int W = 2,
	parameter logic [W-1:0] RST_VAL = '1
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// asynchronous side
	input wire logic [W-1:0] async_in,
	// synchronised side
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// first stage feeds only the second; idle-high reset avoids a false start
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule
`default_nettype wire

// file: hw/plrb_curve.sv
// brightness curve evaluator with global gain
`timescale 1ns/1ps
`default_nettype none
module plrb_curve (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// configuration and picture level
	input wire plrb_pkg::plrb_curve_cfg_type cfg,
	input wire logic [9:0] average_picture_level,
	// result
	output logic [7:0] curve_luminance
);
	import plrb_pkg::*;

	logic [NUM_PTS-1:0][10:0] pos;
	logic [2:0] sel;
	logic [7:0] curve_luminance_ff;

	// positions and segment search; a point past the top is never selected
	always_comb begin
		sel = 3'h0;
		for (int i = 0; i < NUM_PTS; i++) begin
			// RULE_07: fixed spacing
			pos[i] = {1'b0, cfg.start} + 11'(i) * PT_SPACING;
		end
		for (int i = 1; i < NUM_PTS; i++) begin
			// RULE_08: discard beyond top
			if (pos[i] <= {1'b0, average_picture_level} && pos[i] <= APL_MAX) begin
				sel = 3'(i);
			end
		end
	end

	wire [2:0] nsel = sel + 3'h1;
	wire [7:0] l0 = cfg.level[sel];
	wire [7:0] l1 = cfg.level[nsel];
	wire below = {1'b0, average_picture_level} < pos[0];
	// RULE_08: flat after last point
	wire next_ok = (sel != 3'h7) && (pos[nsel] <= APL_MAX);
	wire [10:0] offs = {1'b0, average_picture_level} - pos[sel];
	wire signed [8:0] diff = $signed({1'b0, l1}) - $signed({1'b0, l0});
	wire signed [17:0] prod = diff * $signed({2'h0, offs[6:0]});
	wire signed [17:0] step = prod >>> 7;
	wire signed [17:0] interp = $signed({10'h000, l0}) + step;
	// RULE_06: level per point
	wire [7:0] level = (below || !next_ok) ? l0 : interp[7:0];
	// RULE_10: linear gain, 255 gives unity
	wire [15:0] gprod = level * cfg.gain;
	wire [15:0] gscaled = gprod + {8'h00, gprod[15:8]} + 16'h0001;

	// result registered so the output is glitch free
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			curve_luminance_ff <= 8'h00;
		end else begin
			curve_luminance_ff <= gscaled[15:8];
		end
	end

	assign curve_luminance = curve_luminance_ff;
endmodule
`default_nettype wire

// file: hw/plrb_top.sv
// panel luminance register bank behind a two-wire target port
//
// How it works
// RULE_01: target at 0xf0, 11-bit address, bytes
// RULE_02: validity byte is read only
// RULE_03: bit 6 enables power limiter, reset one
// RULE_04: bit 4 enables power-down sequence
// RULE_05: dimming start from two registers, ten bits
// RULE_06: eight curve point levels in order
// RULE_07: points spaced 128 after point zero
// RULE_08: flat after point seven, drop past 1023
// RULE_09: refresh mode disabled when bit set
// RULE_10: global gain scales all points linearly
// RULE_11: bit 7 enables junction balancing
// RULE_12: temperature reading read only, high first
// RULE_13: sync on at 11, off at 00
// RULE_14: window select two, four, eight frames
// RULE_15: small downward peak changes are ignored
// RULE_16: host keeps module id in 1..1000
// RULE_17: host keeps group id nonzero
// RULE_18: final peak and transmit count read only
// RULE_19: initial peak sets output peak
// RULE_20: unused bits and addresses read zero
// RULE_21: address two bytes, then auto-increment
`timescale 1ns/1ps
`default_nettype none
module plrb_top (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// two-wire target pins, sda open drain
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// status from the module logic
	input wire logic [7:0] validity_byte,
	input wire logic [15:0] temperature_reading,
	input wire logic [9:0] final_peak_luminance,
	input wire logic [9:0] transmit_counter,
	// picture level and per-frame peak samples
	input wire logic [9:0] average_picture_level,
	input wire logic [9:0] peak_sample,
	input wire logic peak_sample_valid,
	// feature controls
	output logic power_limiter_enable,
	output logic power_down_sequence,
	output logic refresh_mode_function,
	output logic balancing_enable,
	// curve result
	output logic [7:0] curve_luminance,
	// peak synchronisation settings and result
	output logic peak_sync,
	output logic [3:0] average_window_select,
	output logic [7:0] peak_hysteresis_threshold,
	output logic [9:0] module_identifier,
	output logic [9:0] group_identifier,
	output logic [9:0] initial_peak_luminance,
	output logic [9:0] peak_held
);
	import plrb_pkg::*;

	logic [1:0] pins_sync;
	logic scl_prev_ff;
	logic sda_prev_ff;
	plrb_state_type state_ff;
	plrb_state_type nxt_state;
	logic [3:0] bit_cnt_ff;
	logic [3:0] nxt_bit_cnt;
	logic [7:0] shift_ff;
	logic [7:0] nxt_shift;
	logic [7:0] tx_ff;
	logic [7:0] nxt_tx;
	logic [10:0] addr_ff;
	logic [10:0] nxt_addr;
	logic rw_ff;
	logic nxt_rw;
	logic mack_ff;
	logic nxt_mack;
	logic sda_oe_ff;
	logic nxt_sda_oe;
	logic wr_stb;
	logic [7:0] rd_data;
	logic [7:0] feat_ff;
	logic [7:0] start_lo_ff;
	logic [7:0][7:0] level_ff;
	logic [7:0] refresh_ff;
	logic [7:0] gain_ff;
	logic [7:0] sync_ff;
	logic [7:0] hyst_ff;
	logic [7:0] mid_hi_ff;
	logic [7:0] mid_lo_ff;
	logic [7:0] gid_hi_ff;
	logic [7:0] gid_lo_ff;
	logic [7:0] init_hi_ff;
	logic [7:0] init_lo_ff;
	logic [7:0] bal_ff;
	logic [9:0] peak_held_ff;
	logic [9:0] nxt_peak_held;
	plrb_curve_cfg_type curve_cfg;

	// pins are asynchronous to mclk, so both pass two flops first
	plrb_sync #(
		.W(2),
		.RST_VAL(2'h3)
	) u_pin_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_in({scl_in, sda_in}),
		.sync_out(pins_sync)
	);

	// bus edges and conditions on the synchronised levels
	wire scl = pins_sync[1];
	wire sda = pins_sync[0];
	wire scl_rise = scl & ~scl_prev_ff;
	wire scl_fall = ~scl & scl_prev_ff;
	wire start_cond = scl & scl_prev_ff & sda_prev_ff & ~sda;
	wire stop_cond = scl & scl_prev_ff & ~sda_prev_ff & sda;

	// RULE_21: reads past the first byte use the next address
	wire [10:0] rd_addr = (state_ff == ST_RD) ? addr_ff + 11'h001 : addr_ff;
	wire rd_lvl = (rd_addr >= OFF_P0) && (rd_addr <= OFF_P7);
	wire [10:0] rd_lvl_off = rd_addr - OFF_P0;
	wire wr_lvl = wr_stb && (addr_ff >= OFF_P0) && (addr_ff <= OFF_P7);
	wire [10:0] wr_lvl_off = addr_ff - OFF_P0;

	// edge history
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end else begin
			scl_prev_ff <= scl;
			sda_prev_ff <= sda;
		end
	end

	// byte sequencer; sda changes only after a detected scl fall, so the
	// synchroniser delay must stay well inside the scl low time
	always_comb begin
		nxt_state = state_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_shift = shift_ff;
		nxt_tx = tx_ff;
		nxt_addr = addr_ff;
		nxt_rw = rw_ff;
		nxt_mack = mack_ff;
		nxt_sda_oe = sda_oe_ff;
		wr_stb = 1'b0;
		if (start_cond) begin
			nxt_state = ST_DEV;
			nxt_bit_cnt = 4'hf; // the start's own scl fall wraps it to zero
			nxt_sda_oe = 1'b0;
		end else if (stop_cond) begin
			nxt_state = ST_IDLE;
			nxt_sda_oe = 1'b0;
		end else if (state_ff != ST_IDLE) begin
			if (scl_rise) begin
				if (bit_cnt_ff != 4'h8) begin
					nxt_shift = {shift_ff[6:0], sda};
				end else begin
					nxt_mack = ~sda;
				end
			end else if (scl_fall) begin
				if (bit_cnt_ff == 4'h7) begin
					nxt_bit_cnt = 4'h8;
					case (state_ff)
						ST_DEV: begin
							// RULE_01: answer only our address
							if (shift_ff[7:1] == DEV_ADDR7) begin
								nxt_sda_oe = 1'b1;
								nxt_rw = shift_ff[0];
							end else begin
								nxt_state = ST_IDLE;
							end
						end
						ST_ADRH: begin
							// RULE_21: high address byte first
							nxt_addr = {shift_ff[2:0], addr_ff[7:0]};
							nxt_sda_oe = 1'b1;
						end
						ST_ADRL: begin
							nxt_addr = {addr_ff[10:8], shift_ff};
							nxt_sda_oe = 1'b1;
						end
						ST_WR: begin
							// any address is acked, unmapped ones just drop the data
							wr_stb = 1'b1;
							nxt_sda_oe = 1'b1;
						end
						ST_RD: begin
							nxt_sda_oe = 1'b0; // let the host ack
						end
						default: begin
							nxt_state = ST_IDLE;
						end
					endcase
				end else if (bit_cnt_ff == 4'h8) begin
					nxt_bit_cnt = 4'h0;
					nxt_sda_oe = 1'b0;
					case (state_ff)
						ST_DEV: begin
							if (rw_ff) begin
								nxt_state = ST_RD;
								nxt_tx = rd_data;
								nxt_sda_oe = ~rd_data[7];
							end else begin
								nxt_state = ST_ADRH;
							end
						end
						ST_ADRH: begin
							nxt_state = ST_ADRL;
						end
						ST_ADRL: begin
							nxt_state = ST_WR;
						end
						ST_WR: begin
							// RULE_21: auto-increment
							nxt_addr = addr_ff + 11'h001;
						end
						ST_RD: begin
							if (mack_ff) begin
								nxt_addr = addr_ff + 11'h001;
								nxt_tx = rd_data;
								nxt_sda_oe = ~rd_data[7];
							end else begin
								nxt_state = ST_IDLE;
							end
						end
						default: begin
							nxt_state = ST_IDLE;
						end
					endcase
				end else begin
					nxt_bit_cnt = bit_cnt_ff + 4'h1;
					if (state_ff == ST_RD) begin
						nxt_tx = {tx_ff[6:0], 1'b0};
						nxt_sda_oe = ~tx_ff[6];
					end
				end
			end
		end
	end

	// sequencer registers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			bit_cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			tx_ff <= 8'h00;
			addr_ff <= 11'h000;
			rw_ff <= 1'b0;
			mack_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			bit_cnt_ff <= nxt_bit_cnt;
			shift_ff <= nxt_shift;
			tx_ff <= nxt_tx;
			addr_ff <= nxt_addr;
			rw_ff <= nxt_rw;
			mack_ff <= nxt_mack;
			sda_oe_ff <= nxt_sda_oe;
		end
	end

	// read mux
	always_comb begin
		rd_data = 8'h00;
		if (rd_lvl) begin
			rd_data = level_ff[rd_lvl_off[2:0]];
		end else begin
			case (rd_addr)
				// RULE_02: validity byte
				OFF_VALID: rd_data = validity_byte;
				OFF_FEAT: rd_data = feat_ff;
				OFF_START_LO: rd_data = start_lo_ff;
				OFF_REFRESH: rd_data = refresh_ff;
				OFF_GAIN: rd_data = gain_ff;
				OFF_SYNC: rd_data = sync_ff;
				OFF_HYST: rd_data = hyst_ff;
				OFF_MID_HI: rd_data = mid_hi_ff;
				OFF_MID_LO: rd_data = mid_lo_ff;
				OFF_GID_HI: rd_data = gid_hi_ff;
				OFF_GID_LO: rd_data = gid_lo_ff;
				// RULE_18: status words, upper bits first
				OFF_PEAK_HI: rd_data = {6'h00, final_peak_luminance[9:8]};
				OFF_PEAK_LO: rd_data = final_peak_luminance[7:0];
				OFF_TXC_HI: rd_data = {6'h00, transmit_counter[9:8]};
				OFF_TXC_LO: rd_data = transmit_counter[7:0];
				OFF_INIT_HI: rd_data = init_hi_ff;
				OFF_INIT_LO: rd_data = init_lo_ff;
				OFF_BAL: rd_data = bal_ff;
				// RULE_12: temperature word
				OFF_TEMP_HI: rd_data = temperature_reading[15:8];
				OFF_TEMP_LO: rd_data = temperature_reading[7:0];
				// RULE_20: unmapped reads zero
				default: rd_data = 8'h00;
			endcase
		end
	end

	// register writes; read-only offsets have no case item and are untouched
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			// RULE_03: limiter on after reset
			feat_ff <= FEAT_RST;
			start_lo_ff <= REG_RST;
			level_ff <= '0;
			// RULE_09: refresh mode enabled after reset
			refresh_ff <= REG_RST;
			gain_ff <= GAIN_RST;
			sync_ff <= REG_RST;
			hyst_ff <= REG_RST;
			mid_hi_ff <= REG_RST;
			mid_lo_ff <= REG_RST;
			gid_hi_ff <= REG_RST;
			gid_lo_ff <= REG_RST;
			init_hi_ff <= REG_RST;
			init_lo_ff <= REG_RST;
			bal_ff <= REG_RST;
		end else if (wr_lvl) begin
			// RULE_06: points zero to seven in order
			level_ff[wr_lvl_off[2:0]] <= shift_ff;
		end else if (wr_stb) begin
			// RULE_20: masks keep unused bits zero
			case (addr_ff)
				OFF_FEAT: feat_ff <= shift_ff & FEAT_MASK;
				OFF_START_LO: start_lo_ff <= shift_ff;
				OFF_REFRESH: refresh_ff <= shift_ff & REFRESH_MASK;
				OFF_GAIN: gain_ff <= shift_ff;
				OFF_SYNC: sync_ff <= shift_ff & SYNC_MASK;
				OFF_HYST: hyst_ff <= shift_ff;
				OFF_MID_HI: mid_hi_ff <= shift_ff & HI2_MASK;
				OFF_MID_LO: mid_lo_ff <= shift_ff;
				OFF_GID_HI: gid_hi_ff <= shift_ff & HI2_MASK;
				OFF_GID_LO: gid_lo_ff <= shift_ff;
				OFF_INIT_HI: init_hi_ff <= shift_ff & HI2_MASK;
				OFF_INIT_LO: init_lo_ff <= shift_ff;
				OFF_BAL: bal_ff <= shift_ff & BAL_MASK;
				default: feat_ff <= feat_ff;
			endcase
		end
	end

	// RULE_05: ten-bit dimming start
	assign curve_cfg.start = {feat_ff[1:0], start_lo_ff};
	assign curve_cfg.level = level_ff;
	assign curve_cfg.gain = gain_ff;

	plrb_curve u_curve (
		.mclk(mclk),
		.rst_n(rst_n),
		.cfg(curve_cfg),
		.average_picture_level(average_picture_level),
		.curve_luminance(curve_luminance)
	);

	// RULE_15: downward steps under threshold held
	wire [9:0] peak_drop = peak_held_ff - peak_sample;
	wire peak_take = (peak_sample >= peak_held_ff) || (peak_drop >= {2'h0, hyst_ff});
	wire [9:0] init_peak = {init_hi_ff[1:0], init_lo_ff};
	// RULE_13: only pattern 11 switches sync on
	wire sync_on = sync_ff[1:0] == SYNC_ON;

	// RULE_19: initial peak drives output while sync is off
	always_comb begin
		nxt_peak_held = peak_held_ff;
		if (!sync_on) begin
			nxt_peak_held = init_peak;
		end else if (peak_sample_valid && peak_take) begin
			nxt_peak_held = peak_sample;
		end
	end

	// held peak; starting from the initial value avoids a jump at sync on
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			peak_held_ff <= 10'h000;
		end else begin
			peak_held_ff <= nxt_peak_held;
		end
	end

	// RULE_14: window frame count, 00 gives 0
	assign average_window_select = (sync_ff[3:2] == WIN_2) ? 4'h2 :
		(sync_ff[3:2] == WIN_4) ? 4'h4 :
		(sync_ff[3:2] == WIN_8) ? 4'h8 : 4'h0;

	// RULE_03: limiter enable
	assign power_limiter_enable = feat_ff[FEAT_LIMIT_BIT];
	// RULE_04: power-down sequence enable
	assign power_down_sequence = feat_ff[FEAT_PDOWN_BIT];
	// RULE_09: set bit disables refresh mode
	assign refresh_mode_function = ~refresh_ff[REFRESH_DIS_BIT];
	// RULE_11: balancing enable
	assign balancing_enable = bal_ff[BAL_EN_BIT];

	// id values pass through unchecked; keeping them legal is the host's job
	assign peak_sync = sync_on;
	assign peak_hysteresis_threshold = hyst_ff;
	assign module_identifier = {mid_hi_ff[1:0], mid_lo_ff};
	assign group_identifier = {gid_hi_ff[1:0], gid_lo_ff};
	assign initial_peak_luminance = init_peak;
	assign peak_held = peak_held_ff;

	// open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe = sda_oe_ff;
endmodule
`default_nettype wire

// file: test/plrb_top_props.sv
// port-level assertions of the panel luminance register bank
`timescale 1ns/1ps
`default_nettype none
module plrb_top_props (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// bus pins
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// feature controls
	input wire logic power_limiter_enable,
	input wire logic power_down_sequence,
	input wire logic refresh_mode_function,
	input wire logic balancing_enable,
	// peak synchronisation
	input wire logic peak_sync,
	input wire logic [3:0] average_window_select,
	input wire logic [7:0] peak_hysteresis_threshold,
	input wire logic [9:0] module_identifier,
	input wire logic [9:0] initial_peak_luminance,
	input wire logic [9:0] peak_sample,
	input wire logic peak_sample_valid,
	input wire logic [9:0] peak_held
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// downward step only, a rise gives zero so it always counts as taken
	wire logic [9:0] drop = (peak_sample < peak_held) ? peak_held - peak_sample : 10'h000;
	wire logic small_drop = (drop != 10'h000) && (drop < {2'h0, peak_hysteresis_threshold});
	a_reset_defaults: assert property (disable iff (1'b0) !rst_n |=> power_limiter_enable
		&& refresh_mode_function && !power_down_sequence && !balancing_enable && !peak_sync)
		else $error("feature outputs left their reset defaults");
	a_reset_release: assert property (disable iff (1'b0) !rst_n |=> !sda_oe)
		else $error("data pin pulled during reset");
	a_drain_low: assert property (!sda_out)
		else $error("data pin output value not low");
	// data pin moves only while bus clock low
	a_oe_clock_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
		else $error("data pin changed with bus clock high");
	// controls change only at a write commit
	a_ctrl_commit: assert property ($changed({power_limiter_enable, power_down_sequence,
		refresh_mode_function, balancing_enable, peak_sync}) |-> !scl_in)
		else $error("feature control changed outside a write");
	// parameters change only at a write commit
	a_param_commit: assert property ($changed({average_window_select, peak_hysteresis_threshold,
		module_identifier, initial_peak_luminance}) |-> !scl_in)
		else $error("parameter output changed outside a write");
	a_window_code: assert property (average_window_select inside {4'h0, 4'h2, 4'h4, 4'h8})
		else $error("window select outside its codes");
	// initial peak used while sync off
	a_peak_initial: assert property (!peak_sync && !$past(peak_sync) |->
		peak_held == $past(initial_peak_luminance))
		else $error("held peak not following initial peak");
	a_peak_keep: assert property (peak_sync && peak_sample_valid && small_drop |=> $stable(peak_held))
		else $error("small peak drop was taken");
	a_peak_take: assert property (peak_sync && peak_sample_valid && !small_drop |=>
		peak_held == $past(peak_sample))
		else $error("peak sample not taken");
endmodule
bind plrb_top plrb_top_props chk_u (.mclk, .rst_n, .scl_in, .sda_out, .sda_oe, .power_limiter_enable,
	.power_down_sequence, .refresh_mode_function, .balancing_enable, .peak_sync, .average_window_select,
	.peak_hysteresis_threshold, .module_identifier, .initial_peak_luminance, .peak_sample,
	.peak_sample_valid, .peak_held);
`default_nettype wire

// file: test/plrb_host_model.sv
// two-wire host model for the register bank's target pins
`timescale 1ns/1ps
`default_nettype none
module plrb_host_model (
	// pacing clock
	input wire logic mclk,
	// bus pins, data open drain with pull-up
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	import plrb_pkg::*;
	// bus clock stands high between frames
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// low 5 cycles, high 3: long low phase covers the target's synchroniser lag
	task automatic bit_x(input logic b, output logic r);
		tick(2);
		sda_low = !b;
		tick(3);
		scl = 1'b1;
		tick(3);
		r = sda;
		scl = 1'b0;
	endtask
	task automatic start();
		tick(2);
		sda_low = 1'b0;
		tick(2);
		scl = 1'b1;
		tick(4);
		sda_low = 1'b1;
		tick(4);
		scl = 1'b0;
	endtask
	task automatic stop();
		tick(2);
		sda_low = 1'b1;
		tick(3);
		scl = 1'b1;
		tick(4);
		sda_low = 1'b0;
		tick(4);
	endtask
	// eight bits most significant first, then the acknowledge bit
	task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] r, output logic ak);
		for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
		bit_x(a, ak);
	endtask
	task automatic addr_ph(input logic [10:0] a, output logic nak);
		logic [7:0] r;
		logic k0, k1, k2;
		start();
		xbyte({DEV_ADDR7, 1'b0}, 1'b1, r, k0);
		xbyte({5'h00, a[10:8]}, 1'b1, r, k1);
		xbyte(a[7:0], 1'b1, r, k2);
		nak = k0 | k1 | k2;
	endtask
	task automatic wr(input logic [10:0] a, input logic [15:0] d, input int n, output logic nak);
		logic [7:0] r;
		logic k;
		addr_ph(a, nak);
		if (n == 2) begin
			xbyte(d[15:8], 1'b1, r, k);
			nak = nak | k;
		end
		xbyte(d[7:0], 1'b1, r, k);
		nak = nak | k;
		stop();
	endtask
	// two bytes: acknowledge the first, refuse the second to end the read
	task automatic rd(input logic [10:0] a, output logic [15:0] v, output logic nak);
		logic k;
		addr_ph(a, nak);
		start();
		xbyte({DEV_ADDR7, 1'b1}, 1'b1, v[15:8], k);
		nak = nak | k;
		xbyte(8'hff, 1'b0, v[15:8], k);
		xbyte(8'hff, 1'b1, v[7:0], k);
		stop();
	endtask
endmodule
`default_nettype wire

// file: test/test_panel_luminance_register_bank.sv
// self-checking bench of the panel luminance register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
	$display("unexpected at %0t got %h expected %h", $time, (a), (e)); end end
module test_panel_luminance_register_bank;
	import plrb_pkg::*;
	typedef struct {logic [10:0] a; logic [7:0] w; logic [15:0] e;} plrb_row_type;
	localparam logic [7:0] VALID_V = 8'h5c;
	localparam logic [15:0] TEMP_V = 16'hbe37;
	localparam logic [9:0] PEAK_V = 10'h2a5;
	localparam logic [9:0] TXC_V = 10'h13c;
	int n_mismatch = 0;
	int compares = 0;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic nak;
	logic [15:0] v;
	logic [7:0] validity_byte = VALID_V;
	logic [15:0] temperature_reading = TEMP_V;
	logic [9:0] final_peak_luminance = PEAK_V;
	logic [9:0] transmit_counter = TXC_V;
	logic [9:0] average_picture_level = 10'h000;
	logic [9:0] peak_sample = 10'h000;
	logic peak_sample_valid = 1'b0;
	wire logic scl_in, sda_low, sda_out, sda_oe, power_limiter_enable, power_down_sequence;
	wire logic refresh_mode_function, balancing_enable, peak_sync;
	wire logic [7:0] curve_luminance, peak_hysteresis_threshold;
	wire logic [3:0] average_window_select;
	wire logic [9:0] module_identifier, group_identifier, initial_peak_luminance, peak_held;
	// open-drain data line with pull-up
	wire logic sda_in = !(sda_oe || sda_low);
	logic [3:0] wins [4] = '{4'h0, 4'h2, 4'h4, 4'h8};
	logic [19:0] pk [3] = '{{10'h2f0, 10'h300}, {10'h2e0, 10'h2e0}, {10'h3ff, 10'h3ff}};
	// write, then two-byte read back: second byte shows the next address
	plrb_row_type rows [16] = '{
		'{OFF_FEAT, 8'hff, 16'h5300},
		'{OFF_START_LO, 8'h81, 16'h8100},
		'{OFF_P7, 8'h72, 16'h7200},
		'{OFF_REFRESH, 8'hff, 16'h1000},
		'{OFF_GAIN, 8'h80, 16'h8000},
		'{OFF_SYNC, 8'hff, 16'h0f00},
		'{OFF_HYST, 8'h20, 16'h2000},
		'{OFF_MID_HI, 8'hff, 16'h0300},
		'{OFF_GID_HI, 8'hfe, 16'h0200},
		'{OFF_INIT_HI, 8'h03, 16'h0300},
		'{OFF_BAL, 8'hff, {8'h80, TEMP_V[15:8]}},
		'{OFF_VALID, 8'h00, {VALID_V, 8'h53}},
		'{OFF_PEAK_HI, 8'h00, {6'h00, PEAK_V}},
		'{OFF_TXC_HI, 8'h00, {6'h00, TXC_V}},
		'{OFF_TEMP_HI, 8'h00, TEMP_V},
		'{11'h7ff, 8'h55, {8'h00, VALID_V}}
	};
	plrb_top dut_u (.mclk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe, .validity_byte, .temperature_reading,
		.final_peak_luminance, .transmit_counter, .average_picture_level, .peak_sample, .peak_sample_valid,
		.power_limiter_enable, .power_down_sequence, .refresh_mode_function, .balancing_enable, .curve_luminance,
		.peak_sync, .average_window_select, .peak_hysteresis_threshold, .module_identifier, .group_identifier,
		.initial_peak_luminance, .peak_held);
	plrb_host_model host_u (.mclk, .scl(scl_in), .sda_low, .sda(sda_in));
	// 40 MHz clock
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic done_test(input string s);
		$display("test %s done, %0d compares", s, compares);
	endtask
	task automatic complete_run();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic wr1(input logic [10:0] a, input logic [7:0] d);
		host_u.wr(a, {8'h00, d}, 1, nak);
		`CHK(nak, 1'b0)
	endtask
	task automatic rd_chk(input logic [10:0] a, input logic [15:0] e);
		host_u.rd(a, v, nak);
		`CHK(v, e)
	endtask
	// main sequence, all inputs move just after a falling edge
	initial begin
		tick(3);
		rst_n = 1'b1;
		tick(3);
		`CHK({power_limiter_enable, refresh_mode_function, power_down_sequence, balancing_enable}, 4'hc)
		rd_chk(OFF_FEAT, 16'h4000);
		done_test("reset");
		foreach (rows[i]) begin
			wr1(rows[i].a, rows[i].w);
			rd_chk(rows[i].a, rows[i].e);
		end
		done_test("register table");
		`CHK({power_limiter_enable, power_down_sequence, refresh_mode_function, balancing_enable}, 4'hd)
		`CHK({peak_sync, average_window_select, peak_hysteresis_threshold}, 13'h1820)
		host_u.wr(OFF_MID_HI, 16'h03e8, 2, nak);
		host_u.wr(OFF_GID_HI, 16'h0201, 2, nak);
		`CHK({module_identifier, group_identifier, initial_peak_luminance}, {10'h3e8, 10'h201, 10'h300})
		for (int k = 0; k < 4; k++) begin
			wr1(OFF_SYNC, {4'h0, k[1:0], k[1:0]});
			`CHK({peak_sync, average_window_select}, {k == 3, wins[k]})
			if (k == 0) `CHK(peak_held, 10'h300)
		end
		done_test("peak settings");
		foreach (pk[i]) begin
			peak_sample = pk[i][19:10];
			peak_sample_valid = 1'b1;
			tick(1);
			peak_sample_valid = 1'b0;
			tick(1);
			`CHK(peak_held, pk[i][9:0])
		end
		done_test("peak hysteresis");
		wr1(OFF_FEAT, 8'h40);
		`CHK(power_down_sequence, 1'b0)
		wr1(OFF_START_LO, 8'h00);
		wr1(OFF_GAIN, 8'hff);
		for (int k = 0; k < 8; k++) wr1(OFF_P0 + 11'(k), 8'(10 * k + 5));
		for (int k = 0; k < 9; k++) begin
			average_picture_level = (k == 8) ? 10'h3ff : 10'(128 * k);
			tick(2);
			`CHK(curve_luminance, 8'(10 * (k < 8 ? k : 7) + 5))
		end
		wr1(OFF_P7, 8'hc8);
		wr1(OFF_GAIN, 8'h80);
		tick(2);
		`CHK(curve_luminance, 8'h64)
		wr1(OFF_GAIN, 8'h00);
		tick(2);
		`CHK(curve_luminance, 8'h00)
		done_test("curve");
		host_u.start();
		host_u.xbyte(8'he0, 1'b1, v[7:0], nak);
		host_u.stop();
		`CHK(nak, 1'b1)
		rd_chk(OFF_VALID, {VALID_V, 8'h40});
		done_test("foreign address");
		rst_n = 1'b0;
		tick(3);
		rst_n = 1'b1;
		tick(3);
		`CHK({power_limiter_enable, refresh_mode_function, peak_sync, peak_held}, 13'h1800)
		rd_chk(OFF_GAIN, 16'hff00);
		done_test("second reset");
		complete_run();
	end
endmodule
`default_nettype wire
